//--- rtl/rtc_status_and_alarm_irq.sv
// Purpose: supervisory bits and alarm/periodic interrupt pins of an rtc
// Assumes: time tick and match inputs come from the timekeeping logic
// Notes:   interrupt pins are open drain, drive and enable for each pin, plus a spare output on pin a
//
// Summary of operation
// RL1 - rise from zero volts clears both control registers and adjustment register
// RL2 - threshold select 0 picks 2.1 V compare, 1 picks 1.3 V
// RL3 - status register holds power-up D4, oscillator D5, low supply D6
// RL4 - power-up and low-supply active high; oscillator bit low means halted
// RL5 - power-up and low-supply clear-only; oscillator bit takes 0 and 1
// RL6 - power-up from zero sets power-up flag, clears low-supply flag
// RL7 - oscillator stop drives oscillator bit low until software writes it
// RL8 - while power-up flag is 1, listed control bits and flags held zero
// RL9 - supply sampled 7.8 ms each second; below threshold sets low-supply
// RL10 - sampling stops while low-supply set, resumes after software clears it
// RL11 - weekly alarm on day-hour-minute match, daily on hour-minute match
// RL12 - weekly alarm on pin b; daily and periodic on pin a, low
// RL13 - periodic output is pulse train or level, chosen by select
// RL14 - status register holds daily D0, weekly D1, periodic D2 flags
// RL15 - control register holds weekly D7, daily D6, select D2..D0
// RL16 - all enables zero after power-on leaves both pins released
// RL17 - pin a low while daily alarm or periodic source asserts
// RL18 - software reads daily and periodic flags to find pin a source
// RL19 - alarm enable 1 arms its circuit, 0 disables it
// RL20 - writing 1 to alarm flag does nothing; 0 clears and releases pin
// RL21 - clearing alarm flag keeps enable; alarm fires at next match
// RL22 - select codes: off, low, 2 Hz, 1 Hz, second, minute, hour, month
// RL23 - level mode pulls pin a low until periodic flag cleared
// RL24 - alarm flag set in same cycle pin asserts
`timescale 1ns/1ps
`default_nettype none
module rtc_status_and_alarm_irq
  import rtc_irq_pkg::*;
(
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RESET_IN,
  input  wire logic       POWER_FROM_ZERO_IN,
  input  wire logic       OSC_STOPPED_IN,
  input  wire logic       SECOND_TICK_IN,
  input  wire logic       HALF_SECOND_PHASE_IN,
  input  wire logic       MINUTE_TICK_IN,
  input  wire logic       HOUR_TICK_IN,
  input  wire logic       MONTH_TICK_IN,
  input  wire logic       WEEKLY_MATCH_IN,
  input  wire logic       DAILY_MATCH_IN,
  input  wire logic       BELOW_2V1_IN,
  input  wire logic       BELOW_1V3_IN,
  input  wire logic [3:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  input  wire logic       REG_WRITE_IN,
  output logic      [7:0] REG_RDATA_OUT,
  output logic            SAMPLE_ENABLE_OUT,
  output logic            IRQ_A_IN_UNUSED_OUT,
  output logic            IRQ_OUT_A_OUT,
  output logic            IRQ_OUT_A_OE_OUT,
  output logic            IRQ_OUT_B_OUT,
  output logic            IRQ_OUT_B_OE_OUT,
  output logic      [7:0] ADJUST_OUT
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]      ctrl_q;
  logic [7:0]      ctrl_d;
  logic [7:0]      adj_q;
  logic [7:0]      adj_d;
  logic            pwr_up_q;
  logic            low_supply_q;
  logic            osc_run_q;
  logic            thr_sel_q;
  logic            clk_dis_a_q;
  logic [7:0]      rdata_q;
  logic            sec_cnt_done;
  logic [31:0]     samp_cnt_q;
  monitor_state_t  mon_q;
  monitor_state_t  mon_d;
  flag_if          fl ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // shared by the write strobes and the read mux
  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] want);
    return a == want;
  endfunction : addr_is
  wire hit_ctrl   = addr_is(REG_ADDR_IN, ADDR_INT_EN_CTRL);
  wire hit_status = addr_is(REG_ADDR_IN, ADDR_STATUS_CTRL);
  wire hit_adj    = addr_is(REG_ADDR_IN, ADDR_ADJUST);
  wire wr_ctrl    = REG_WRITE_IN && hit_ctrl;
  wire wr_status  = REG_WRITE_IN && hit_status;
  wire wr_adj     = REG_WRITE_IN && hit_adj;
  // RL8 power-up holds cleared
  wire wipe      = pwr_up_q;
  wire [2:0] psel = ctrl_q[PSEL_HI:0];

  // ----------------------------------------------------------------
  // control and adjustment registers
  // ----------------------------------------------------------------
  // RL1 cleared on power rise
  assign ctrl_d = (POWER_FROM_ZERO_IN || wipe) ? CLEARED_VALUE :
                  wr_ctrl ? REG_WDATA_IN : ctrl_q;
  assign adj_d  = (POWER_FROM_ZERO_IN || wipe) ? CLEARED_VALUE :
                  wr_adj ? REG_WDATA_IN : adj_q;
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      ctrl_q <= CLEARED_VALUE;
      adj_q  <= CLEARED_VALUE;
    end else begin
      ctrl_q <= ctrl_d;
      adj_q  <= adj_d;
    end
  end

  // ----------------------------------------------------------------
  // monitor bits
  // ----------------------------------------------------------------
  wire thr_sel_d   = (POWER_FROM_ZERO_IN || wipe) ? 1'b0 :
                     wr_status ? REG_WDATA_IN[THR_SEL_BIT] : thr_sel_q;
  wire clk_dis_a_d = (POWER_FROM_ZERO_IN || wipe) ? 1'b0 :
                     wr_status ? REG_WDATA_IN[CLK_DIS_A_BIT] : clk_dis_a_q;
  // RL2 threshold selection
  wire below_thr   = thr_sel_q ? BELOW_1V3_IN : BELOW_2V1_IN;
  // RL9 sample sets flag
  wire low_set     = (mon_q == MON_SAMPLE) && below_thr && !wipe;
  // RL6 power rise sets flag
  // RL5 clear-only power-up bit
  wire pwr_up_d     = POWER_FROM_ZERO_IN ? 1'b1 :
                      (wr_status && !REG_WDATA_IN[PWR_UP_BIT]) ? 1'b0 : pwr_up_q;
  // RL5 clear-only low-supply, set wins
  wire low_supply_d = (POWER_FROM_ZERO_IN || wipe) ? 1'b0 :
                      low_set ? 1'b1 :
                      (wr_status && !REG_WDATA_IN[LOW_SUPPLY_BIT]) ? 1'b0 :
                      low_supply_q;
  // RL7 halt forces low, holds
  // RL4 osc bit active low
  wire osc_run_d    = OSC_STOPPED_IN ? 1'b0 :
                      wr_status ? REG_WDATA_IN[OSC_RUN_BIT] : osc_run_q;
  // reset counts as a rise from zero, so the power-up flag starts set
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      pwr_up_q     <= 1'b1;
      low_supply_q <= 1'b0;
    end else begin
      pwr_up_q     <= pwr_up_d;
      low_supply_q <= low_supply_d;
    end
  end
  // oscillator bit keeps its value across a rise from zero
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      osc_run_q <= 1'b0;
    end else begin
      osc_run_q <= osc_run_d;
    end
  end
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      thr_sel_q   <= 1'b0;
      clk_dis_a_q <= 1'b0;
    end else begin
      thr_sel_q   <= thr_sel_d;
      clk_dis_a_q <= clk_dis_a_d;
    end
  end

  // ----------------------------------------------------------------
  // supply sampling window
  // ----------------------------------------------------------------
  assign sec_cnt_done = (samp_cnt_q == SAMPLE_CYCLES - 1);
  always_comb begin
    mon_d = mon_q;
    case (mon_q)
      MON_IDLE: begin
        // RL10 no sampling while set
        if (SECOND_TICK_IN && !low_supply_q) begin
          mon_d = MON_SAMPLE;
        end
      end
      MON_SAMPLE: begin
        if (low_set || low_supply_q) begin
          mon_d = MON_HOLD;
        end else if (sec_cnt_done) begin
          mon_d = MON_IDLE;
        end
      end
      MON_HOLD: begin
        if (!low_supply_q) begin
          mon_d = MON_IDLE;
        end
      end
      default: mon_d = MON_IDLE;
    endcase
  end
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      mon_q      <= MON_IDLE;
      samp_cnt_q <= 32'h0;
    end else begin
      mon_q      <= mon_d;
      samp_cnt_q <= (mon_d == MON_SAMPLE && mon_q == MON_SAMPLE) ? samp_cnt_q + 32'h1 : 32'h0;
    end
  end
  // registered copy of the window state, so the pin never glitches
  logic sample_en_q;
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      sample_en_q <= 1'b0;
    end else begin
      sample_en_q <= (mon_d == MON_SAMPLE);
    end
  end
  assign SAMPLE_ENABLE_OUT = sample_en_q;

  // ----------------------------------------------------------------
  // interrupt sources
  // ----------------------------------------------------------------
  // RL19 enable gates alarm
  // RL11 weekly and daily match
  // RL21 enable kept after clear
  wire weekly_hit = ctrl_q[WEEKLY_EN_BIT] && WEEKLY_MATCH_IN;
  wire daily_hit  = ctrl_q[DAILY_EN_BIT] && DAILY_MATCH_IN;
  wire level_mode = psel[2];
  wire [3:0] period_tick = {MONTH_TICK_IN, HOUR_TICK_IN, MINUTE_TICK_IN, SECOND_TICK_IN};
  logic [3:0] period_hit;
  genvar p;
  generate
    // RL22 level-mode period select
    for (p = 0; p < 4; p++) begin : g_period
      // level codes run second, minute, hour, month upward
      assign period_hit[p] = (psel == PSEL_SECOND + 3'(p)) && period_tick[p];
    end
  endgenerate
  wire level_hit  = |period_hit;
  // RL24 flags set with pin
  assign fl.set = {level_hit, weekly_hit, daily_hit} & {3{!wipe}};
  // RL20 write zero clears
  assign fl.clr = {3{wr_status}} & ~REG_WDATA_IN[PERIODIC_BIT:DAILY_FLAG_BIT];
  irq_flag_bank u_flags (
    .clk_in  (CORE_CLK_IN),
    .rst_in  (RESET_IN),
    .wipe_in (wipe),
    .fl      (fl)
  );
  wire daily_flag    = fl.flags[DAILY_FLAG_BIT];
  wire weekly_flag   = fl.flags[WEEKLY_FLAG_BIT];
  wire periodic_flag = fl.flags[PERIODIC_BIT];

  // ----------------------------------------------------------------
  // 1 hz pulse phase
  // ----------------------------------------------------------------
  // toggles on each rise of the 2 hz phase; its alignment to the
  // second tick is fixed only by reset, a known limitation
  logic hz1_low_q;
  logic half_prev_q;
  // previous-phase reset level matches the idle pin, so no false edge
  wire  half_rise = HALF_SECOND_PHASE_IN && !half_prev_q;
  // RL22 half rate of 2 Hz
  wire  hz1_low_d = half_rise ? !hz1_low_q : hz1_low_q;
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      half_prev_q <= 1'b0;
      hz1_low_q   <= 1'b0;
    end else begin
      half_prev_q <= HALF_SECOND_PHASE_IN;
      hz1_low_q   <= hz1_low_d;
    end
  end

  // RL13 pulse or level form
  // RL22 pulse and fixed codes
  logic periodic_low;
  always_comb begin
    case (psel)
      PSEL_OFF: periodic_low = 1'b0;
      PSEL_LOW: periodic_low = 1'b1;
      PSEL_2HZ: periodic_low = HALF_SECOND_PHASE_IN;
      PSEL_1HZ: periodic_low = hz1_low_q;
      default:  periodic_low = level_mode & periodic_flag;
    endcase
  end
  // 2 Hz form follows the timebase phase directly, 1 Hz form a registered toggle of it; neither sets a flag

  // ----------------------------------------------------------------
  // open-drain pins
  // ----------------------------------------------------------------
  // RL23 level held until cleared
  // RL17 pin a is wired-or
  // RL12 sources onto pins
  // RL16 idle pins released
  wire pin_a_low = daily_flag | periodic_low;
  wire pin_b_low = weekly_flag;
  assign IRQ_OUT_A_OUT       = 1'b0;
  assign IRQ_OUT_A_OE_OUT    = pin_a_low;
  assign IRQ_OUT_B_OUT       = 1'b0;
  assign IRQ_OUT_B_OE_OUT    = pin_b_low;
  assign IRQ_A_IN_UNUSED_OUT = 1'b0;
  assign ADJUST_OUT          = adj_q;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // RL3 monitor bit positions
  // RL14 flag bit positions
  wire [7:0] status_view = {thr_sel_q, low_supply_q, osc_run_q, pwr_up_q,
                            clk_dis_a_q, periodic_flag, weekly_flag, daily_flag};
  // RL15 control layout
  wire [7:0] rd_sel = hit_ctrl   ? ctrl_q :
                      hit_status ? status_view :
                      hit_adj    ? adj_q : 8'h00;
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_sel;
    end
  end
  assign REG_RDATA_OUT = rdata_q;
endmodule : rtc_status_and_alarm_irq
`default_nettype wire

//--- pkg/rtc_irq_pkg.sv
// Purpose: constants for the rtc supervisory and alarm interrupt block
// Assumes: register port carries 4-bit address, 8-bit data
// Notes:   timing counts derived from the 100 MHz core clock
package rtc_irq_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_INT_EN_CTRL  = 4'he;
  localparam logic [3:0] ADDR_STATUS_CTRL  = 4'hf;
  localparam logic [3:0] ADDR_ADJUST       = 4'h7;
  // interrupt_enable_control fields
  localparam int WEEKLY_EN_BIT   = 7;
  localparam int DAILY_EN_BIT    = 6;
  localparam int HOUR_FMT_BIT    = 5;
  localparam int CLK_DIS_B_BIT   = 4;
  localparam int TEST_BIT        = 3;
  localparam int PSEL_HI         = 2;
  // status_flag_control fields
  localparam int THR_SEL_BIT     = 7;
  localparam int LOW_SUPPLY_BIT  = 6;
  localparam int OSC_RUN_BIT     = 5;
  localparam int PWR_UP_BIT      = 4;
  localparam int CLK_DIS_A_BIT   = 3;
  localparam int PERIODIC_BIT    = 2;
  localparam int WEEKLY_FLAG_BIT = 1;
  localparam int DAILY_FLAG_BIT  = 0;
  localparam logic [7:0] CLEARED_VALUE   = 8'h00;
  localparam logic [7:0] STATUS_PWR_UP   = 8'h10;
  // ----------------------------------------------------------------
  // periodic select encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] PSEL_OFF     = 3'h0;
  localparam logic [2:0] PSEL_LOW     = 3'h1;
  localparam logic [2:0] PSEL_2HZ     = 3'h2;
  localparam logic [2:0] PSEL_1HZ     = 3'h3;
  localparam logic [2:0] PSEL_SECOND  = 3'h4;
  localparam logic [2:0] PSEL_MINUTE  = 3'h5;
  localparam logic [2:0] PSEL_HOUR    = 3'h6;
  localparam logic [2:0] PSEL_MONTH   = 3'h7;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 10000;
  localparam int SAMPLE_TIME_US10  = 78;    // 7.8 ms in units of 0.1 ms
  // divide first: the plain product would overflow a 32-bit int
  localparam int SAMPLE_CYCLES     = SAMPLE_TIME_US10 * (100000000 / CLK_PERIOD_PS);
  typedef enum logic [1:0] {MON_IDLE, MON_SAMPLE, MON_HOLD} monitor_state_t;
endpackage : rtc_irq_pkg

//--- pkg/flag_if.sv
// Purpose: carries flag set and clear strobes to the flag bank
// Assumes: single clock domain
// Notes:   one bit per sticky flag
`timescale 1ns/1ps
`default_nettype none
interface flag_if;
  logic [2:0] set;
  logic [2:0] clr;
  logic [2:0] flags;
  modport ctrl (output set, output clr, input flags);
  modport bank (input set, input clr, output flags);
endinterface : flag_if
`default_nettype wire

//--- rtl/irq_flag_bank.sv
// Purpose: sticky interrupt flags daily, weekly, periodic
// Assumes: set and clear are one-cycle strobes
// Notes:   a set in the clear cycle wins
`timescale 1ns/1ps
`default_nettype none
module irq_flag_bank (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic wipe_in,
  flag_if.bank      fl
);
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  // ----------------------------------------------------------------
  // flag storage
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_flag
      // RL20 zero clears flag
      assign flags_d[i] = fl.set[i] | (flags_q[i] & ~fl.clr[i] & ~wipe_in);
    end
  endgenerate
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= flags_d;
    end
  end
  assign fl.flags = flags_q;
endmodule : irq_flag_bank
`default_nettype wire

//--- testbench/host_irq_model.sv
// Purpose: host side of the two open-drain interrupt lines
// Assumes: board pull-ups on both lines
// Notes:   a released line reads high, never the last driven level
`timescale 1ns/1ps
`default_nettype none
module host_irq_model (
  input  wire logic drv_a_in,
  input  wire logic oe_a_in,
  input  wire logic drv_b_in,
  input  wire logic oe_b_in,
  output logic      pin_a_out,
  output logic      pin_b_out
);
  assign pin_a_out = oe_a_in ? drv_a_in : 1'b1;
  assign pin_b_out = oe_b_in ? drv_b_in : 1'b1;
  // host reads flags to find source, done by the bench reads
endmodule : host_irq_model
`default_nettype wire

//--- testbench/rtc_irq_chk.sv
// Purpose: port-level checks of the rtc interrupt block
// Assumes: one clock, sync active-high reset
// Notes:   power-up flag tracked locally from writes
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_chk (
  input wire logic       CORE_CLK_IN,
  input wire logic       RESET_IN,
  input wire logic       POWER_FROM_ZERO_IN,
  input wire logic       SECOND_TICK_IN,
  input wire logic       WEEKLY_MATCH_IN,
  input wire logic       BELOW_2V1_IN,
  input wire logic       BELOW_1V3_IN,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic       REG_WRITE_IN,
  input wire logic       SAMPLE_ENABLE_OUT,
  input wire logic       IRQ_OUT_A_OUT,
  input wire logic       IRQ_OUT_A_OE_OUT,
  input wire logic       IRQ_OUT_B_OUT,
  input wire logic       IRQ_OUT_B_OE_OUT,
  input wire logic [7:0] ADJUST_OUT
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // 7.8 ms at 100 MHz
  localparam int WIN_MAX = 780000;
  logic        pwr_q;
  logic [19:0] win_q;
  wire logic   stat_wr = REG_WRITE_IN && REG_ADDR_IN == 4'hf;
  wire logic   b_clr   = stat_wr && !REG_WDATA_IN[1];
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN || POWER_FROM_ZERO_IN) pwr_q <= 1'b1;
    else if (stat_wr && !REG_WDATA_IN[4]) pwr_q <= 1'b0;
  end
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN || !SAMPLE_ENABLE_OUT) win_q <= 20'h0;
    else win_q <= win_q + 20'h1;
  end
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);
  AST_RST_QUIET: assert property (
    $fell(RESET_IN) |-> !IRQ_OUT_A_OE_OUT && !IRQ_OUT_B_OE_OUT && ADJUST_OUT == 8'h00)
    else $error("pins or adjust not cleared at reset");
  AST_OD_LOW: assert property (
    !IRQ_OUT_A_OUT && !IRQ_OUT_B_OUT)
    else $error("open-drain pin drives high");
  AST_B_SRC: assert property (
    $rose(IRQ_OUT_B_OE_OUT) |-> $past(WEEKLY_MATCH_IN))
    else $error("pin b fell without weekly match");
  AST_B_CLEAR: assert property (
    b_clr && !WEEKLY_MATCH_IN |=> !IRQ_OUT_B_OE_OUT)
    else $error("pin b not released by flag clear");
  AST_B_HOLD: assert property (
    IRQ_OUT_B_OE_OUT && !b_clr && !POWER_FROM_ZERO_IN && !pwr_q
    && !(REG_WRITE_IN && REG_ADDR_IN == 4'he) |=> IRQ_OUT_B_OE_OUT)
    else $error("pin b released without clear");
  AST_SMP_CAUSE: assert property (
    $rose(SAMPLE_ENABLE_OUT) |-> $past(SECOND_TICK_IN))
    else $error("sampling opened without second tick");
  AST_SMP_STOP: assert property (
    SAMPLE_ENABLE_OUT && BELOW_2V1_IN && BELOW_1V3_IN && !pwr_q
    |-> ##[1:4] !SAMPLE_ENABLE_OUT)
    else $error("sampling kept on after low supply");
  AST_SMP_LEN: assert property (
    win_q <= 20'(WIN_MAX))
    else $error("sampling window too long");
endmodule : rtc_irq_chk
bind rtc_status_and_alarm_irq rtc_irq_chk chk_u (
  .CORE_CLK_IN(CORE_CLK_IN), .RESET_IN(RESET_IN), .POWER_FROM_ZERO_IN(POWER_FROM_ZERO_IN),
  .SECOND_TICK_IN(SECOND_TICK_IN), .WEEKLY_MATCH_IN(WEEKLY_MATCH_IN),
  .BELOW_2V1_IN(BELOW_2V1_IN), .BELOW_1V3_IN(BELOW_1V3_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WRITE_IN(REG_WRITE_IN),
  .SAMPLE_ENABLE_OUT(SAMPLE_ENABLE_OUT), .IRQ_OUT_A_OUT(IRQ_OUT_A_OUT),
  .IRQ_OUT_A_OE_OUT(IRQ_OUT_A_OE_OUT), .IRQ_OUT_B_OUT(IRQ_OUT_B_OUT),
  .IRQ_OUT_B_OE_OUT(IRQ_OUT_B_OE_OUT), .ADJUST_OUT(ADJUST_OUT));
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: register-level directed test of the rtc interrupt block
// Assumes: one-cycle write strobe, read data one cycle late
// Notes:   full 7.8 ms window never run, too long for the bench
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rtc_irq_pkg::*;
;
  logic       clk, rst, osc, half, lo2, lo1, we;
  logic [6:0] tk;
  logic [3:0] addr;
  logic [7:0] wd, rdat, adj;
  logic       smp, oa, ea, ob, eb, pin_a, pin_b, spare;
  int         error_cnt, checked;
  rtc_status_and_alarm_irq dut_u (.CORE_CLK_IN(clk), .RESET_IN(rst),
    .POWER_FROM_ZERO_IN(tk[6]), .OSC_STOPPED_IN(osc), .SECOND_TICK_IN(tk[0]),
    .HALF_SECOND_PHASE_IN(half), .MINUTE_TICK_IN(tk[1]), .HOUR_TICK_IN(tk[2]),
    .MONTH_TICK_IN(tk[3]), .WEEKLY_MATCH_IN(tk[4]), .DAILY_MATCH_IN(tk[5]),
    .BELOW_2V1_IN(lo2), .BELOW_1V3_IN(lo1), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd),
    .REG_WRITE_IN(we), .REG_RDATA_OUT(rdat), .SAMPLE_ENABLE_OUT(smp),
    .IRQ_A_IN_UNUSED_OUT(spare), .IRQ_OUT_A_OUT(oa), .IRQ_OUT_A_OE_OUT(ea),
    .IRQ_OUT_B_OUT(ob), .IRQ_OUT_B_OE_OUT(eb), .ADJUST_OUT(adj));
  host_irq_model host_u (.drv_a_in(oa), .oe_a_in(ea), .drv_b_in(ob), .oe_b_in(eb),
    .pin_a_out(pin_a), .pin_b_out(pin_b));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk(rdat, exp);
  endtask : rd
  task automatic pulse(input int i);
    @(posedge clk);
    tk[i] <= 1'b1;
    @(posedge clk);
    tk[i] <= 1'b0;
  endtask : pulse
  task automatic pins(input logic a, input logic b);
    @(negedge clk);
    chk({5'h0, spare, pin_a, pin_b}, {5'h0, 1'b0, a, b});
  endtask : pins
  task automatic give_verdict;
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {osc, half, lo2, lo1, we, tk, addr, wd} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_STATUS_CTRL, STATUS_PWR_UP);
    wr(ADDR_INT_EN_CTRL, 8'hff);
    rd(ADDR_INT_EN_CTRL, 8'h00);
    rd(4'h3, 8'h00);
    wr(ADDR_STATUS_CTRL, 8'h70);
    rd(ADDR_STATUS_CTRL, 8'h30);
    wr(ADDR_STATUS_CTRL, 8'h20);
    rd(ADDR_STATUS_CTRL, 8'h20);
    wr(ADDR_ADJUST, 8'h46);
    rd(ADDR_ADJUST, 8'h46);
    @(posedge clk) osc <= 1'b1;
    @(posedge clk) osc <= 1'b0;
    rd(ADDR_STATUS_CTRL, 8'h00);
    wr(ADDR_STATUS_CTRL, 8'h20);
    pins(1'b1, 1'b1);
    wr(ADDR_INT_EN_CTRL, 8'hc0);
    pulse(4);
    pins(1'b1, 1'b0);
    rd(ADDR_STATUS_CTRL, 8'h22);
    pulse(5);
    pins(1'b0, 1'b0);
    wr(ADDR_STATUS_CTRL, 8'h23);
    rd(ADDR_STATUS_CTRL, 8'h23);
    wr(ADDR_STATUS_CTRL, 8'h21);
    pins(1'b0, 1'b1);
    rd(ADDR_INT_EN_CTRL, 8'hc0);
    pulse(4);
    pins(1'b0, 1'b0);
    wr(ADDR_STATUS_CTRL, 8'h20);
    pins(1'b1, 1'b1);
    wr(ADDR_INT_EN_CTRL, 8'h00);
    pulse(4);
    pulse(5);
    pins(1'b1, 1'b1);
    for (int k = 4; k < 8; k++) begin
      wr(ADDR_INT_EN_CTRL, {5'h0, 3'(k)});
      pulse(k - 4);
      pins(1'b0, 1'b1);
      rd(ADDR_STATUS_CTRL, 8'h24);
      wr(ADDR_STATUS_CTRL, 8'h20);
      pins(1'b1, 1'b1);
    end
    wr(ADDR_INT_EN_CTRL, {2'h1, 3'h0, PSEL_LOW});
    pulse(5);
    rd(ADDR_STATUS_CTRL, 8'h21);
    wr(ADDR_STATUS_CTRL, 8'h20);
    pins(1'b0, 1'b1);
    wr(ADDR_INT_EN_CTRL, {5'h0, PSEL_2HZ});
    @(posedge clk) half <= 1'b1;
    repeat (2) @(posedge clk);
    pins(1'b0, 1'b1);
    wr(ADDR_INT_EN_CTRL, {5'h0, PSEL_1HZ});
    pins(1'b0, 1'b1);
    @(posedge clk) half <= 1'b0;
    @(posedge clk) half <= 1'b1;
    repeat (2) @(posedge clk);
    pins(1'b1, 1'b1);
    wr(ADDR_INT_EN_CTRL, {5'h0, PSEL_OFF});
    pins(1'b1, 1'b1);
    pulse(0);
    @(negedge clk) chk({7'h0, smp}, 8'h01);
    @(posedge clk) lo2 <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk) chk({7'h0, smp}, 8'h00);
    rd(ADDR_STATUS_CTRL, 8'h60);
    wr(ADDR_STATUS_CTRL, 8'ha0);
    pulse(0);
    repeat (4) @(posedge clk);
    rd(ADDR_STATUS_CTRL, 8'ha0);
    @(posedge clk) lo1 <= 1'b1;
    pulse(0);
    repeat (4) @(posedge clk);
    rd(ADDR_STATUS_CTRL, 8'he0);
    wr(ADDR_INT_EN_CTRL, 8'hc4);
    pulse(6);
    // oscillator bit is left alone by a rise from zero
    rd(ADDR_STATUS_CTRL, STATUS_PWR_UP | 8'h20);
    rd(ADDR_INT_EN_CTRL, 8'h00);
    rd(ADDR_ADJUST, 8'h00);
    chk(adj, 8'h00);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
